// File: core/atx_switch_pkg.sv
package atx_switch_pkg;

    // ****************************************
    // timing
    // ****************************************
    localparam int CLK_PERIOD_NS = 40;
    localparam int TICK_PERIOD_NS = 31_250_000;
    localparam int TICK_CYCLES_DEF = TICK_PERIOD_NS / CLK_PERIOD_NS;
    localparam int TICK_US = 31_250;
    localparam int HOLD_LONG_US = 4_000_000;
    localparam int HOLD_SHORT_US = 250_000;
    localparam int RESET_PULSE_US = 1_000_000;
    localparam int EXTRA_HOLD_US = 5_000_000;
    // least times round up, the extension limit (a longest time) rounds down
    localparam logic [7:0] HOLD_LONG_TICKS = 8'((HOLD_LONG_US + TICK_US - 1) / TICK_US);
    localparam logic [7:0] HOLD_SHORT_TICKS = 8'((HOLD_SHORT_US + TICK_US - 1) / TICK_US);
    localparam logic [7:0] RESET_PULSE_TICKS = 8'((RESET_PULSE_US + TICK_US - 1) / TICK_US);
    localparam logic [7:0] EXTRA_HOLD_TICKS = 8'(EXTRA_HOLD_US / TICK_US);

    // ****************************************
    // command packet
    // ****************************************
    localparam logic [7:0] CMD_TYPE_ATX = 8'h1C;
    localparam logic [7:0] ACK_TYPE_ATX = 8'h5C;
    localparam logic [7:0] CMD_LEN_MIN = 8'h01;
    localparam logic [7:0] CMD_LEN_MAX = 8'h03;
    localparam int CMD_TYPE_LSB = 0;
    localparam int CMD_D0_LSB = 8;
    localparam int CMD_D1_LSB = 16;
    localparam int CMD_D2_LSB = 24;

    // function mask bits
    localparam int BIT_AUTO_POL = 0;
    localparam int BIT_RST_INV = 1;
    localparam int BIT_PWR_INV = 2;
    localparam int BIT_BLANK = 4;
    localparam int BIT_KEY_RST = 5;
    localparam int BIT_KEY_ON = 6;
    localparam int BIT_KEY_OFF = 7;

    localparam logic [7:0] MASK_RST = 8'h00;
    localparam logic [7:0] PULSE_LEN_RST = 8'h20;
    localparam logic SENSE_SEL_RST = 1'b1;

    // ****************************************
    // register map
    // ****************************************
    localparam int ADDR_W = 8;
    localparam logic [7:0] REG_CMD = 8'h00;
    localparam logic [7:0] REG_LEN = 8'h04;
    localparam logic [7:0] REG_ACK = 8'h08;
    localparam logic [7:0] REG_CFG = 8'h0C;
    localparam logic [7:0] REG_STAT = 8'h10;
    localparam int ACK_VALID_BIT = 8;
    localparam int ACK_ERR_BIT = 9;
    localparam int CFG_MASK_LSB = 0;
    localparam int CFG_PULSE_LSB = 8;
    localparam int CFG_SENSE_BIT = 16;
    localparam int STAT_SENSE_BIT = 0;
    localparam int STAT_CONFIRM_BIT = 1;
    localparam int STAT_CANCEL_BIT = 2;
    localparam int STAT_FSM_LSB = 3;
    localparam int STAT_MSG_LSB = 6;
    localparam int STAT_BLANK_BIT = 8;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    localparam int SYNC_W = 6;

    // ****************************************
    // types
    // ****************************************
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_RST_PULSE = 3'b001,
        ST_PWR_PULSE = 3'b010,
        ST_PWR_EXTEND = 3'b011,
        ST_LOCKED = 3'b100
    } fsm_e;

    typedef enum logic [1:0] {
        MSG_NONE = 2'b00,
        MSG_RESET = 2'b01,
        MSG_POWER_ON = 2'b10,
        MSG_POWER_OFF = 2'b11
    } msg_e;

    typedef struct packed {
        logic awvalid;
        logic [ADDR_W-1:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [ADDR_W-1:0] araddr;
        logic rready;
    } axil_req_s;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } axil_rsp_s;

    typedef struct packed {
        logic o;
        logic oe;
    } line_out_s;

endpackage : atx_switch_pkg

// File: core/pin_sync.sv
`timescale 1ns/100ps

module pin_sync
    import atx_switch_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // pins
    input wire logic [SYNC_W-1:0] pinRaw,
    output logic [SYNC_W-1:0] pinSync
);

    typedef struct packed {
        logic [SYNC_W-1:0] meta;
        logic [SYNC_W-1:0] sync;
    } sync_s;

    sync_s st;
    sync_s nxt;

    // the first stage feeds only the second stage
    always_comb
    begin
        nxt.meta = pinRaw;
        nxt.sync = st.meta;
    end

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            st <= '0;
        else
            st <= nxt;
    end

    assign pinSync = st.sync;

endmodule : pin_sync

// File: core/atx_power_reset_switch_ctrl.sv
// Our own choices: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/100ps

module atx_power_reset_switch_ctrl
    import atx_switch_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYCLES_DEF
)
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // register bus
    input wire axil_req_s axilReq,
    output axil_rsp_s axilRsp,
    // sense and keys
    input wire logic senseInt,
    input wire logic sensePin1,
    input wire logic keyConfirm,
    input wire logic keyCancel,
    // host switch lines
    input wire logic rstLineIn,
    input wire logic pwrLineIn,
    output line_out_s rstLine,
    output line_out_s pwrLine,
    // display and module
    output logic displayBlank,
    output logic backlightOff,
    output logic selfReset,
    output msg_e messageCode
);

    typedef struct packed {
        logic awHeld;
        logic [ADDR_W-1:0] awAddr;
        logic wHeld;
        logic [31:0] wData;
        logic [3:0] wStrb;
        logic bValid;
        logic [1:0] bResp;
        logic rValid;
        logic [31:0] rData;
        logic [1:0] rResp;
        logic [31:0] cmdWord;
        logic [7:0] cmdLen;
        logic ackValid;
        logic ackErr;
        logic [7:0] mask;
        logic [7:0] pulseLen;
        logic senseSel;
        fsm_e fsm;
        msg_e msg;
        logic [19:0] tickCnt;
        logic tick;
        logic [7:0] holdCnt;
        logic [7:0] phase;
        logic senseOld;
        logic rstIdle;
        logic pwrIdle;
        logic idleSeen;
        logic rstOe;
        logic rstOut;
        logic pwrOe;
        logic pwrOut;
        logic blank;
        logic selfReset;
    } state_s;

    state_s st;
    state_s nxt;
    logic [SYNC_W-1:0] pinS;
    logic senseHost;
    logic confirmQual;
    logic cancelQual;
    logic cmdFire;
    logic execGood;
    logic execBad;
    logic [31:0] cmdNow;
    logic [7:0] holdThr;
    logic awReady;
    logic wReady;
    logic arReady;

    function automatic logic [ADDR_W-1:0] regSel(input logic [ADDR_W-1:0] addr);
        regSel = {addr[ADDR_W-1:2], 2'b00};
    endfunction : regSel

    // auto mode drives against the level the line rests at when released
    function automatic logic driveLevel(input logic autoPol, input logic inv,
                                        input logic idleLvl);
        driveLevel = autoPol ? ~idleLvl : inv;
    endfunction : driveLevel

    pin_sync u_pin_sync (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .pinRaw({pwrLineIn, rstLineIn, keyCancel, keyConfirm, sensePin1, senseInt}),
        .pinSync(pinS)
    );

    assign awReady = ~st.awHeld & ~st.bValid;
    assign wReady = ~st.wHeld & ~st.bValid;
    assign arReady = ~st.rValid;

    always_comb
    begin
        nxt = st;
        cmdFire = 1'b0;
        execGood = 1'b0;
        execBad = 1'b0;
        cmdNow = st.cmdWord;
        senseHost = st.senseSel ? pinS[0] : pinS[1];
        // ****************************************
        // register bus write
        // ****************************************
        if (axilReq.awvalid && awReady)
        begin
            nxt.awHeld = 1'b1;
            nxt.awAddr = axilReq.awaddr;
        end
        if (axilReq.wvalid && wReady)
        begin
            nxt.wHeld = 1'b1;
            nxt.wData = axilReq.wdata;
            nxt.wStrb = axilReq.wstrb;
        end
        if (st.bValid && axilReq.bready)
            nxt.bValid = 1'b0;
        if (st.awHeld && st.wHeld)
        begin
            nxt.awHeld = 1'b0;
            nxt.wHeld = 1'b0;
            nxt.bValid = 1'b1;
            nxt.bResp = RESP_OKAY;
            case (regSel(st.awAddr))
                REG_CMD:
                begin
                    for (int i = 0; i < 4; i++)
                        if (st.wStrb[i])
                            cmdNow[i*8 +: 8] = st.wData[i*8 +: 8];
                    nxt.cmdWord = cmdNow;
                    cmdFire = 1'b1;
                end
                REG_LEN:
                    if (st.wStrb[0])
                        nxt.cmdLen = st.wData[7:0];
                REG_ACK, REG_CFG, REG_STAT: ;
                default: nxt.bResp = RESP_SLVERR;
            endcase
        end
        // ****************************************
        // register bus read
        // ****************************************
        if (st.rValid && axilReq.rready)
            nxt.rValid = 1'b0;
        if (axilReq.arvalid && arReady)
        begin
            nxt.rValid = 1'b1;
            nxt.rResp = RESP_OKAY;
            nxt.rData = '0;
            case (regSel(axilReq.araddr))
                REG_CMD: nxt.rData = st.cmdWord;
                REG_LEN: nxt.rData[7:0] = st.cmdLen;
                REG_ACK:
                begin
                    nxt.rData[7:0] = ACK_TYPE_ATX;
                    nxt.rData[ACK_VALID_BIT] = st.ackValid;
                    nxt.rData[ACK_ERR_BIT] = st.ackErr;
                    // reading consumes the answer; a new one below still wins
                    nxt.ackValid = 1'b0;
                    nxt.ackErr = 1'b0;
                end
                REG_CFG:
                begin
                    nxt.rData[CFG_MASK_LSB +: 8] = st.mask;
                    nxt.rData[CFG_PULSE_LSB +: 8] = st.pulseLen;
                    nxt.rData[CFG_SENSE_BIT] = st.senseSel;
                end
                REG_STAT:
                begin
                    nxt.rData[STAT_SENSE_BIT] = senseHost;
                    nxt.rData[STAT_CONFIRM_BIT] = pinS[2];
                    nxt.rData[STAT_CANCEL_BIT] = pinS[3];
                    nxt.rData[STAT_FSM_LSB +: 3] = st.fsm;
                    nxt.rData[STAT_MSG_LSB +: 2] = st.msg;
                    nxt.rData[STAT_BLANK_BIT] = st.blank;
                end
                default: nxt.rResp = RESP_SLVERR;
            endcase
        end
        // ****************************************
        // command execution
        // ****************************************
        if (cmdFire && st.fsm != ST_LOCKED)
        begin
            if (cmdNow[CMD_TYPE_LSB +: 8] == CMD_TYPE_ATX && st.cmdLen >= CMD_LEN_MIN
                && st.cmdLen <= CMD_LEN_MAX)
            begin
                execGood = 1'b1;
                nxt.ackValid = 1'b1;
                nxt.mask = cmdNow[CMD_D0_LSB +: 8];
                // a zero length is outside the legal range and keeps the old one
                if (st.cmdLen >= 8'h02 && cmdNow[CMD_D1_LSB +: 8] != 8'h00)
                    nxt.pulseLen = cmdNow[CMD_D1_LSB +: 8];
                if (st.cmdLen == CMD_LEN_MAX)
                    nxt.senseSel = cmdNow[CMD_D2_LSB];
            end
            else
            begin
                execBad = 1'b1;
                nxt.ackErr = 1'b1;
            end
        end
        // ****************************************
        // 1/32 s timebase
        // ****************************************
        nxt.tick = 1'b0;
        if (st.tickCnt == 20'(TICK_CYCLES - 1))
        begin
            nxt.tickCnt = '0;
            nxt.tick = 1'b1;
        end
        else
            nxt.tickCnt = st.tickCnt + 20'h0_0001;
        // ****************************************
        // key functions
        // ****************************************
        confirmQual = pinS[2] && ((senseHost && st.mask[BIT_KEY_RST])
                      || (!senseHost && st.mask[BIT_KEY_ON]));
        cancelQual = pinS[3] && senseHost && st.mask[BIT_KEY_OFF];
        holdThr = (confirmQual && !senseHost) ? HOLD_SHORT_TICKS : HOLD_LONG_TICKS;
        nxt.selfReset = 1'b0;
        nxt.senseOld = senseHost;
        case (st.fsm)
            ST_IDLE:
            begin
                if (senseHost && !st.senseOld)
                    nxt.selfReset = 1'b1;
                if (!(confirmQual || cancelQual))
                    nxt.holdCnt = '0;
                else if (st.tick)
                begin
                    if (st.holdCnt + 8'h01 == holdThr)
                    begin
                        nxt.holdCnt = '0;
                        nxt.phase = '0;
                        if (confirmQual && senseHost)
                        begin
                            nxt.fsm = ST_RST_PULSE;
                            nxt.msg = MSG_RESET;
                        end
                        else if (confirmQual)
                        begin
                            nxt.fsm = ST_PWR_PULSE;
                            nxt.msg = MSG_POWER_ON;
                        end
                        else
                        begin
                            nxt.fsm = ST_PWR_PULSE;
                            nxt.msg = MSG_POWER_OFF;
                        end
                    end
                    else
                        nxt.holdCnt = st.holdCnt + 8'h01;
                end
            end
            ST_RST_PULSE:
                if (st.tick)
                begin
                    nxt.phase = st.phase + 8'h01;
                    if (st.phase + 8'h01 == RESET_PULSE_TICKS)
                    begin
                        nxt.phase = '0;
                        nxt.fsm = ST_LOCKED;
                    end
                end
            ST_PWR_PULSE:
                if (st.tick)
                begin
                    nxt.phase = st.phase + 8'h01;
                    if (st.phase + 8'h01 >= st.pulseLen)
                    begin
                        nxt.phase = '0;
                        if (st.msg == MSG_POWER_OFF && pinS[3])
                            nxt.fsm = ST_PWR_EXTEND;
                        else if (st.msg == MSG_POWER_ON)
                            nxt.fsm = ST_LOCKED;
                        else
                        begin
                            nxt.fsm = ST_IDLE;
                            nxt.msg = MSG_NONE;
                        end
                    end
                end
            ST_PWR_EXTEND:
                if (!pinS[3] || (st.tick && st.phase + 8'h01 == EXTRA_HOLD_TICKS))
                begin
                    nxt.fsm = ST_IDLE;
                    nxt.msg = MSG_NONE;
                    nxt.phase = '0;
                end
                else if (st.tick)
                    nxt.phase = st.phase + 8'h01;
            ST_LOCKED:
                // one tick lets the host reset settle before the module restarts
                if (st.tick)
                begin
                    nxt.selfReset = 1'b1;
                    nxt.fsm = ST_IDLE;
                    nxt.msg = MSG_NONE;
                end
            default:
            begin
                nxt.fsm = ST_IDLE;
                nxt.msg = MSG_NONE;
            end
        endcase
        // ****************************************
        // line drive and display
        // ****************************************
        // a released line needs the sync delay to show its rest level, so the
        // first idle tick only arms the sampling and later idle ticks take it
        if (st.fsm != ST_IDLE)
            nxt.idleSeen = 1'b0;
        else if (st.tick)
        begin
            nxt.idleSeen = 1'b1;
            if (st.idleSeen)
            begin
                nxt.rstIdle = pinS[4];
                nxt.pwrIdle = pinS[5];
            end
        end
        nxt.rstOe = (nxt.fsm == ST_RST_PULSE);
        nxt.pwrOe = (nxt.fsm == ST_PWR_PULSE) || (nxt.fsm == ST_PWR_EXTEND);
        nxt.rstOut = driveLevel(st.mask[BIT_AUTO_POL], st.mask[BIT_RST_INV], st.rstIdle);
        nxt.pwrOut = driveLevel(st.mask[BIT_AUTO_POL], st.mask[BIT_PWR_INV], st.pwrIdle);
        nxt.blank = st.mask[BIT_BLANK] && !senseHost;
    end

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            st <= '0;
            st.mask <= MASK_RST;
            st.pulseLen <= PULSE_LEN_RST;
            st.senseSel <= SENSE_SEL_RST;
            st.fsm <= ST_IDLE;
            st.msg <= MSG_NONE;
        end
        else
            st <= nxt;
    end

    assign axilRsp = '{awready: awReady, wready: wReady, bvalid: st.bValid, bresp: st.bResp,
                       arready: arReady, rvalid: st.rValid, rdata: st.rData,
                       rresp: st.rResp};
    assign rstLine = '{o: st.rstOut, oe: st.rstOe};
    assign pwrLine = '{o: st.pwrOut, oe: st.pwrOe};
    assign displayBlank = st.blank;
    assign backlightOff = st.blank;
    assign selfReset = st.selfReset;
    assign messageCode = st.msg;

    // ****************************************
    // checks
    // ****************************************
    int rstCycles;
    int pwrCycles;
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rstCycles <= 0;
            pwrCycles <= 0;
        end
        else
        begin
            rstCycles <= st.rstOe ? rstCycles + 1 : 0;
            pwrCycles <= st.pwrOe ? pwrCycles + 1 : 0;
        end
    end

    property p_bad_len;
        @(posedge sys_clk) disable iff (!reset_n)
        cmdFire && st.fsm != ST_LOCKED && (st.cmdLen == 8'h00 || st.cmdLen > 8'h03)
            |=> st.ackErr && $stable(st.mask);
    endproperty
    a_bad_len: assert property (p_bad_len) else $error("bad length not refused");

    property p_ack;
        @(posedge sys_clk) disable iff (!reset_n)
        execGood |=> st.ackValid && st.mask == $past(cmdNow[15:8]);
    endproperty
    a_ack: assert property (p_ack) else $error("accepted command not acknowledged");

    property p_idle_float;
        @(posedge sys_clk) disable iff (!reset_n)
        st.fsm == ST_IDLE || st.fsm == ST_LOCKED |-> !rstLine.oe && !pwrLine.oe;
    endproperty
    a_idle_float: assert property (p_idle_float) else $error("line driven while idle");

    property p_polarity;
        @(posedge sys_clk) disable iff (!reset_n)
        $rose(st.rstOe) |-> st.rstOut
            == ($past(st.mask[0]) ? !$past(pinS[4]) : $past(st.mask[1]));
    endproperty
    a_polarity: assert property (p_polarity) else $error("reset drive level wrong");

    property p_pwr_polarity;
        @(posedge sys_clk) disable iff (!reset_n)
        $rose(st.pwrOe) |-> st.pwrOut
            == ($past(st.mask[0]) ? !$past(pinS[5]) : $past(st.mask[2]));
    endproperty
    a_pwr_polarity: assert property (p_pwr_polarity) else $error("power drive level wrong");

    property p_rst_len;
        @(posedge sys_clk) disable iff (!reset_n)
        $fell(st.rstOe) |-> rstCycles >= (RESET_PULSE_TICKS - 1) * TICK_CYCLES
            && rstCycles <= RESET_PULSE_TICKS * TICK_CYCLES;
    endproperty
    a_rst_len: assert property (p_rst_len) else $error("reset pulse length wrong");

    property p_locked;
        @(posedge sys_clk) disable iff (!reset_n)
        cmdFire && st.fsm == ST_LOCKED |=> $stable(st.mask) && $stable(st.pulseLen);
    endproperty
    a_locked: assert property (p_locked) else $error("command taken while locked");

    property p_extend;
        @(posedge sys_clk) disable iff (!reset_n)
        st.pwrOe |-> pwrCycles < (255 + EXTRA_HOLD_TICKS + 2) * TICK_CYCLES;
    endproperty
    a_extend: assert property (p_extend) else $error("power drive too long");

    property p_blank;
        @(posedge sys_clk) disable iff (!reset_n)
        st.mask[4] && !senseHost ##1 st.mask[4] && !senseHost |-> displayBlank && backlightOff;
    endproperty
    a_blank: assert property (p_blank) else $error("display not blanked");

    property p_restart;
        @(posedge sys_clk) disable iff (!reset_n)
        st.fsm == ST_IDLE && senseHost && !st.senseOld |=> selfReset;
    endproperty
    a_restart: assert property (p_restart) else $error("no restart on sense rise");

    property p_release;
        @(posedge sys_clk) disable iff (!reset_n)
        st.fsm == ST_IDLE && !pinS[2] && !pinS[3] |=> st.holdCnt == 8'h00 && st.fsm == ST_IDLE;
    endproperty
    a_release: assert property (p_release) else $error("hold not cancelled");

endmodule : atx_power_reset_switch_ctrl

// File: tb/host_board.sv
`timescale 1ns/100ps

module host_board
    import atx_switch_pkg::*;
(
    // block side
    input wire line_out_s rstLine,
    input wire line_out_s pwrLine,
    // wire levels
    output logic rstLineIn,
    output logic pwrLineIn
);
    // board pull-ups: a released line rests high, whatever level it was last driven to
    assign rstLineIn = rstLine.oe ? rstLine.o : 1'b1;
    assign pwrLineIn = pwrLine.oe ? pwrLine.o : 1'b1;
endmodule : host_board

// File: tb/test_atx_power_reset_switch_ctrl.sv
`timescale 1ns/100ps

module test_atx_power_reset_switch_ctrl
    import atx_switch_pkg::*;
;
    localparam int TC = 4;
    logic sys_clk = 0, reset_n = 0, senseInt = 1, sensePin1 = 0;
    logic keyConfirm = 0, keyCancel = 0, rstLineIn, pwrLineIn, displayBlank, selfReset;
    axil_req_s req = '0;
    axil_rsp_s rsp;
    line_out_s rstLine, pwrLine;
    msg_e messageCode;
    logic [33:0] q[$];
    logic [31:0] seed = 32'h0000_febd;
    logic [7:0] pl;
    logic backlightOff;
    int n_errors = 0, checks = 0;

    atx_power_reset_switch_ctrl #(.TICK_CYCLES(TC)) dut (.sys_clk(sys_clk), .reset_n(reset_n),
        .axilReq(req), .axilRsp(rsp), .senseInt(senseInt), .sensePin1(sensePin1),
        .keyConfirm(keyConfirm), .keyCancel(keyCancel), .rstLineIn(rstLineIn),
        .pwrLineIn(pwrLineIn), .rstLine(rstLine), .pwrLine(pwrLine),
        .displayBlank(displayBlank), .backlightOff(backlightOff), .selfReset(selfReset),
        .messageCode(messageCode));
    host_board board (.rstLine(rstLine), .pwrLine(pwrLine), .rstLineIn(rstLineIn),
        .pwrLineIn(pwrLineIn));

    initial forever #20 sys_clk = ~sys_clk;

    function automatic logic [31:0] xs(input logic [31:0] v);
        v = v ^ (v << 13);
        v = v ^ (v >> 17);
        return v ^ (v << 5);
    endfunction : xs

    task automatic chk(input logic [33:0] got, input logic [33:0] exp);
        checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task give_verdict;
        $display("checks %0d n_errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : give_verdict

    // handshakes are judged at the negedge, where nothing is moving, and acted on at the posedge
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic ka, kw, kb;
        @(posedge sys_clk);
        req.awvalid <= 1;
        req.awaddr <= a;
        req.wvalid <= 1;
        req.wdata <= d;
        req.wstrb <= 4'hf;
        req.bready <= 1;
        forever
        begin
            @(negedge sys_clk);
            ka = req.awvalid & rsp.awready;
            kw = req.wvalid & rsp.wready;
            kb = rsp.bvalid;
            if (kb) chk(34'(rsp.bresp), 34'(RESP_OKAY));
            @(posedge sys_clk);
            if (ka) req.awvalid <= 0;
            if (kw) req.wvalid <= 0;
            if (kb)
            begin
                req.bready <= 0;
                return;
            end
        end
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [33:0] e);
        logic ka, k;
        q.push_back(e);
        @(posedge sys_clk);
        req.arvalid <= 1;
        req.araddr <= a;
        req.rready <= 1;
        forever
        begin
            @(negedge sys_clk);
            ka = req.arvalid & rsp.arready;
            k = rsp.rvalid;
            @(posedge sys_clk);
            if (ka) req.arvalid <= 0;
            if (k)
            begin
                req.rready <= 0;
                return;
            end
        end
    endtask : rd

    always @(negedge sys_clk)
        if (rsp.rvalid && req.rready && q.size() > 0)
            chk({rsp.rresp, rsp.rdata}, q.pop_front());

    task automatic pulse(input bit s, input logic eo, input int n, input msg_e m);
        int c;
        line_out_s l;
        c = 0;
        repeat (3000)
        begin
            @(negedge sys_clk);
            l = s ? pwrLine : rstLine;
            if (l.oe)
            begin
                c++;
                if (c == 1)
                    chk(34'(messageCode), 34'(m));
                chk(34'(l.o), 34'(eo));
            end
            else if (c > 0) break;
        end
        chk(34'(c), 34'(n));
    endtask : pulse

    task automatic waitSr;
        repeat (200)
        begin
            @(negedge sys_clk);
            if (selfReset) break;
        end
        chk(34'(selfReset), 34'(1));
    endtask : waitSr

    initial
    begin
        repeat (3) @(posedge sys_clk);
        reset_n <= 1;
        rd(REG_CFG, 34'h0_0001_2000);
        wr(REG_LEN, 32'h0000_0004);
        wr(REG_CMD, 32'h0000_001C);
        rd(REG_ACK, 34'h0_0000_025C);
        rd(8'h40, {RESP_SLVERR, 32'h0000_0000});
        seed = xs(seed);
        pl = 8'(seed % 6 + 2);
        wr(REG_LEN, 32'h0000_0003);
        wr(REG_CMD, {8'h00, pl, 8'h54, CMD_TYPE_ATX});
        rd(REG_ACK, 34'h0_0000_015C);
        rd(REG_CFG, {18'h0_0000, pl, 8'h54});
        @(negedge sys_clk) chk(34'({displayBlank, backlightOff}), 34'(2'b11));
        @(posedge sys_clk) keyConfirm <= 1;
        repeat (6 * TC) @(posedge sys_clk);
        keyConfirm <= 0;
        repeat (12 * TC) @(negedge sys_clk) chk(34'(pwrLine.oe), 34'(0));
        @(posedge sys_clk) keyConfirm <= 1;
        pulse(1, 1, pl * TC, MSG_POWER_ON);
        waitSr;
        @(posedge sys_clk) keyConfirm <= 0;
        wr(REG_LEN, 32'h0000_0001);
        wr(REG_CMD, 32'h0000_A11C);
        @(posedge sys_clk) sensePin1 <= 1;
        waitSr;
        @(posedge sys_clk) keyConfirm <= 1;
        pulse(0, 0, 32 * TC, MSG_RESET);
        // lands while the block waits to restart, so it must be ignored
        wr(REG_CMD, 32'h0000_001C);
        waitSr;
        @(posedge sys_clk) keyConfirm <= 0;
        rd(REG_CFG, {18'h0_0000, pl, 8'hA1});
        rd(REG_ACK, 34'h0_0000_015C);
        @(posedge sys_clk) keyCancel <= 1;
        pulse(1, 0, (pl + 160) * TC, MSG_POWER_OFF);
        @(posedge sys_clk) keyCancel <= 0;
        give_verdict;
    end

    initial
    begin
        repeat (20000) @(posedge sys_clk);
        n_errors++;
        give_verdict;
    end
endmodule : test_atx_power_reset_switch_ctrl
